// [bench/low_voltage_detect_control_tb.sv]
// Self-checking bench for the low-voltage detect control block.
// Assumes lvd_pkg is compiled first; the bench plays CPU and comparator.
`default_nettype none

module low_voltage_detect_control_tb
    import lvd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

    logic              core_clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_stb;
    logic              rd_stb;
    logic [DATA_W-1:0] rdata;
    logic              comp_below_raw;
    logic              comp_enable;
    logic [CODE_W-1:0] comp_threshold_code;
    logic              internal_reset;
    logic              undervolt_interrupt;
    int                miscompares;
    int                comparisons;
    int                cycles;

    low_voltage_detect_control dut (
        .core_clk            (core_clk),
        .rst                 (rst),
        .addr                (addr),
        .wdata               (wdata),
        .wr_stb              (wr_stb),
        .rd_stb              (rd_stb),
        .rdata               (rdata),
        .comp_below_raw      (comp_below_raw),
        .comp_enable         (comp_enable),
        .comp_threshold_code (comp_threshold_code),
        .internal_reset      (internal_reset),
        .undervolt_interrupt (undervolt_interrupt)
    );

    // ****************************************
    // Clock and hang guard
    // ****************************************
    // 100 MHz system clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Whole run needs well under a thousand cycles, so 5000 means a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    // One-cycle write strobe; effect lands at the releasing edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    // Comparator level, changed on an edge like every other input
    task automatic below(input logic v);
        @(posedge core_clk);
        comp_below_raw <= v;
        repeat (5) @(posedge core_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        #1;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        comp_below_raw = 1'b0;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        do_reset();
        // Reset values of every register and of every output but comp_threshold_code
        rchk(DETECT_CONTROL_OFFS, CTRL_RESET);
        rchk(THRESHOLD_SELECT_OFFS, {4'h0, SELECT_RESET});
        rchk(IRQ_MASK_0L_OFFS, {7'h00, MASK_RESET});
        rchk(IRQ_REQUEST_0L_OFFS, 8'h00);
        rchk(RESET_CAUSE_OFFS, 8'h00);
        `CHK({comp_enable, internal_reset, undervolt_interrupt}, 3'b000)
        rchk(16'h0000, 8'h00);
        wr(16'hffbd, 8'hff);
        rchk(DETECT_CONTROL_OFFS, 8'h00);
        $display("Test reset values done");

        // All ten codes, then prohibited ones leave the old code in place
        for (int k = 0; k <= 9; k++) begin
            wr(THRESHOLD_SELECT_OFFS, 8'(k));
            rchk(THRESHOLD_SELECT_OFFS, 8'(k));
            `CHK(comp_threshold_code, 4'(k))
        end
        wr(THRESHOLD_SELECT_OFFS, 8'h0a);
        rchk(THRESHOLD_SELECT_OFFS, {4'h0, CODE_MAX});
        wr(THRESHOLD_SELECT_OFFS, 8'h0f);
        rchk(THRESHOLD_SELECT_OFFS, {4'h0, CODE_MAX});
        $display("Test threshold codes done");

        // Interrupt mode: masked start-up, early set, clear, unmask, event
        wr(THRESHOLD_SELECT_OFFS, 8'h03);
        wr(DETECT_CONTROL_OFFS, 8'h80);
        `CHK(comp_enable, 1'b1)
        repeat (20) @(posedge core_clk);
        below(1'b1);
        rchk(DETECT_CONTROL_OFFS, 8'h81);
        rchk(IRQ_REQUEST_0L_OFFS, 8'h01);
        `CHK(undervolt_interrupt, 1'b0)
        wr(IRQ_REQUEST_0L_OFFS, 8'h00);
        wr(IRQ_MASK_0L_OFFS, 8'h00);
        rchk(IRQ_REQUEST_0L_OFFS, 8'h00);
        below(1'b0);
        rchk(DETECT_CONTROL_OFFS, 8'h80);
        below(1'b1);
        `CHK(undervolt_interrupt, 1'b1)
        `CHK(internal_reset, 1'b0)
        wr(IRQ_REQUEST_0L_OFFS, 8'h00);
        below(1'b0);
        `CHK(undervolt_interrupt, 1'b0)
        // Rise of the source lands on the edge that takes a clear
        @(posedge core_clk);
        comp_below_raw <= 1'b1;
        @(posedge core_clk);
        wr(IRQ_REQUEST_0L_OFFS, 8'h00);
        rchk(IRQ_REQUEST_0L_OFFS, 8'h01);
        wr(IRQ_REQUEST_0L_OFFS, 8'h00);
        below(1'b0);
        // Stop by clearing enable only; a later drop must stay silent
        wr(DETECT_CONTROL_OFFS, 8'h00);
        `CHK(comp_enable, 1'b0)
        below(1'b1);
        rchk(DETECT_CONTROL_OFFS, 8'h00);
        `CHK(undervolt_interrupt, 1'b0)
        below(1'b0);
        $display("Test interrupt mode done");

        // Reset mode: read-only bits, no reset on entry, reset on drop
        wr(IRQ_MASK_0L_OFFS, 8'h01);
        wr(DETECT_CONTROL_OFFS, 8'h80);
        repeat (20) @(posedge core_clk);
        rchk(DETECT_CONTROL_OFFS, 8'h80);
        wr(DETECT_CONTROL_OFFS, 8'hff);
        rchk(DETECT_CONTROL_OFFS, 8'h82);
        repeat (4) @(posedge core_clk);
        `CHK(internal_reset, 1'b0)
        below(1'b1);
        `CHK(internal_reset, 1'b1)
        rchk(DETECT_CONTROL_OFFS, 8'h83);
        rchk(IRQ_REQUEST_0L_OFFS, 8'h00);
        below(1'b0);
        `CHK(internal_reset, 1'b0)
        repeat (20) @(posedge core_clk);
        rchk(RESET_CAUSE_OFFS, 8'h01);
        rchk(RESET_CAUSE_OFFS, 8'h00);
        // Enable with mode clear, then clear enable; no reset may follow
        wr(DETECT_CONTROL_OFFS, 8'h80);
        wr(DETECT_CONTROL_OFFS, 8'h00);
        below(1'b1);
        `CHK(internal_reset, 1'b0)
        below(1'b0);
        $display("Test reset mode done");

        // Second external reset in mid-run clears enable and sets the mask
        wr(IRQ_MASK_0L_OFFS, 8'h00);
        wr(DETECT_CONTROL_OFFS, 8'h82);
        do_reset();
        rchk(DETECT_CONTROL_OFFS, 8'h00);
        rchk(IRQ_MASK_0L_OFFS, 8'h01);
        `CHK(comp_enable, 1'b0)
        $display("Test external reset done");
        stop_test();
    end

endmodule

`default_nettype wire

// [src/low_voltage_detect_control.sv]
// Control logic around a supply comparator: enable, threshold, mode,
// interrupt and internal reset generation, and reset cause recording.
// Assumes an analog comparator outside, and a system that resets its
// other logic from internal_reset while this block keeps running.
`default_nettype none

// Operation
// - Reset mode enabled: internal reset asserts while supply is below threshold.
// - Interrupt mode enabled: interrupt request rises when supply drops below threshold.
// - Enable bit, control bit 7, starts the comparator.
// - Below-threshold flag readable at control bit 0.
// - Setting reset mode with supply above threshold gives no reset.
// - External reset sets the interrupt mask.
// - Flag and request may set early; set wins over clear.
// - Threshold code holds ten levels, zero to nine; others prohibited.
// - Flag drives interrupt only with enable set and mode clear.
// - Enable and mode clear on external reset, not on low-voltage reset.
// - Low-voltage reset sets reset-cause bit 0.
module low_voltage_detect_control
    import lvd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              comp_below_raw,
    output logic                   comp_enable,
    output logic      [CODE_W-1:0] comp_threshold_code,
    output logic                   internal_reset,
    output logic                   undervolt_interrupt
);

    logic              detect_enable_bit;
    logic              reset_mode_select;
    logic              below_sync;
    logic              below_threshold_flag;
    logic [CODE_W-1:0] threshold_code;
    logic              irq_source;
    logic              undervolt_irq_request;
    logic              undervolt_irq_mask;
    logic              undervolt_reset_cause;
    logic              wr_ctrl;
    logic              wr_select;
    logic              wr_req;
    logic              wr_mask;
    logic              rd_cause;
    logic [DATA_W-1:0] read_next;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] offs);
        return a == offs;
    endfunction

    assign wr_ctrl   = wr_stb & hit(addr, DETECT_CONTROL_OFFS);
    assign wr_select = wr_stb & hit(addr, THRESHOLD_SELECT_OFFS);
    assign wr_req    = wr_stb & hit(addr, IRQ_REQUEST_0L_OFFS);
    assign wr_mask   = wr_stb & hit(addr, IRQ_MASK_0L_OFFS);
    assign rd_cause  = rd_stb & hit(addr, RESET_CAUSE_OFFS);

    // ****************************************
    // Comparator input
    // ****************************************
    lvd_sync2 u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (comp_below_raw),
        .sync_out (below_sync)
    );

    // Flag reads zero while detection is off
    assign below_threshold_flag = detect_enable_bit & below_sync;

    // ****************************************
    // Control register
    // ****************************************
    // Of the two resets only the external one clears these; the block's own reset leaves them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            detect_enable_bit <= CTRL_RESET[CTRL_ENABLE_POS];
            reset_mode_select <= CTRL_RESET[CTRL_MODE_POS];
        end else if (wr_ctrl) begin
            detect_enable_bit <= wdata[CTRL_ENABLE_POS];
            reset_mode_select <= wdata[CTRL_MODE_POS];
        end
    end

    // ****************************************
    // Threshold select
    // ****************************************
    // Prohibited codes are dropped so the analog side never sees them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            threshold_code <= SELECT_RESET;
        end else if (wr_select && wdata[CODE_W-1:0] <= CODE_MAX) begin
            threshold_code <= wdata[CODE_W-1:0];
        end
    end

    assign comp_enable         = detect_enable_bit;
    assign comp_threshold_code = threshold_code;

    // ****************************************
    // Internal reset and interrupt source
    // ****************************************
    // Level follows the supply, so no reset if above when mode is set
    always_ff @(posedge core_clk) begin
        if (rst) begin
            internal_reset <= 1'b0;
        end else begin
            internal_reset <= detect_enable_bit & reset_mode_select & below_sync;
        end
    end

    // Flag reaches the interrupt only in interrupt mode
    assign irq_source = detect_enable_bit & ~reset_mode_select & below_sync;

    lvd_irq_flag u_irq (
        .core_clk   (core_clk),
        .rst        (rst),
        .irq_source (irq_source),
        .req_wr     (wr_req),
        .req_wdata  (wdata[REQ_POS]),
        .mask_wr    (wr_mask),
        .mask_wdata (wdata[MASK_POS]),
        .req_q      (undervolt_irq_request),
        .mask_q     (undervolt_irq_mask),
        .irq_out    (undervolt_interrupt)
    );

    // ****************************************
    // Reset cause
    // ****************************************
    // Cleared by reading; a new low-voltage reset wins over the read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            undervolt_reset_cause <= 1'b0;
        end else if (internal_reset) begin
            undervolt_reset_cause <= 1'b1;
        end else if (rd_cause) begin
            undervolt_reset_cause <= 1'b0;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        read_next = '0;
        if (rd_stb) begin
            unique case (addr)
                DETECT_CONTROL_OFFS: begin
                    read_next[CTRL_ENABLE_POS] = detect_enable_bit;
                    read_next[CTRL_MODE_POS]   = reset_mode_select;
                    read_next[CTRL_FLAG_POS]   = below_threshold_flag;
                end
                THRESHOLD_SELECT_OFFS: read_next[CODE_W-1:0] = threshold_code;
                IRQ_REQUEST_0L_OFFS:   read_next[REQ_POS]    = undervolt_irq_request;
                IRQ_MASK_0L_OFFS:      read_next[MASK_POS]   = undervolt_irq_mask;
                RESET_CAUSE_OFFS:      read_next[CAUSE_POS]  = undervolt_reset_cause;
                default:               read_next = '0;
            endcase
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= read_next;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_raw_low_held;
        !comp_below_raw [*3];
    endsequence

    sequence s_raw_high_held;
        comp_below_raw [*3];
    endsequence

    a_reset_when_below: assert property (@(posedge core_clk) disable iff (rst)
        detect_enable_bit && reset_mode_select && below_sync |=> internal_reset)
        else $error("internal reset missing while below threshold");

    a_no_reset_above: assert property (@(posedge core_clk) disable iff (rst)
        !below_sync |=> !internal_reset)
        else $error("internal reset asserted while supply above threshold");

    a_irq_on_drop: assert property (@(posedge core_clk) disable iff (rst)
        $rose(irq_source) |=> undervolt_irq_request)
        else $error("interrupt request not raised on drop");

    a_irq_mode_gate: assert property (@(posedge core_clk) disable iff (rst)
        (reset_mode_select || !detect_enable_bit) |-> !irq_source)
        else $error("interrupt source active outside interrupt mode");

    a_enable_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl |=> comp_enable == $past(wdata[CTRL_ENABLE_POS]))
        else $error("enable bit did not follow control write");

    a_flag_read_back: assert property (@(posedge core_clk) disable iff (rst)
        rd_stb && addr == DETECT_CONTROL_OFFS |=>
            rdata[CTRL_FLAG_POS] == $past(detect_enable_bit && below_sync))
        else $error("flag read back wrong");

    a_mask_on_reset: assert property (@(posedge core_clk)
        rst |=> undervolt_irq_mask && !undervolt_interrupt)
        else $error("mask not set by external reset");

    a_reset_clears_ctrl: assert property (@(posedge core_clk)
        rst |=> !detect_enable_bit && !reset_mode_select && !internal_reset)
        else $error("control bits not cleared by external reset");

    a_code_in_range: assert property (@(posedge core_clk) disable iff (rst)
        comp_threshold_code <= CODE_MAX)
        else $error("prohibited threshold code reached comparator");

    a_cause_recorded: assert property (@(posedge core_clk) disable iff (rst)
        internal_reset |=> undervolt_reset_cause ##1 (undervolt_reset_cause || !internal_reset))
        else $error("reset cause not recorded");

    a_early_set_wins: assert property (@(posedge core_clk) disable iff (rst)
        $rose(irq_source) && wr_req && !wdata[REQ_POS] |=> undervolt_irq_request)
        else $error("request lost to same-cycle clear");

    a_sync_rise: assert property (@(posedge core_clk) disable iff (rst)
        s_raw_high_held |-> below_sync)
        else $error("synchronised level late on rise");

    a_sync_fall: assert property (@(posedge core_clk) disable iff (rst)
        s_raw_low_held |-> !below_sync)
        else $error("synchronised level late on fall");

endmodule

`default_nettype wire

// [src/lvd_irq_flag.sv]
// Undervolt interrupt request flag and its mask.
// Assumes the source is a synchronous level on core_clk.
`default_nettype none

module lvd_irq_flag (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic irq_source,
    input  wire logic req_wr,
    input  wire logic req_wdata,
    input  wire logic mask_wr,
    input  wire logic mask_wdata,
    output logic      req_q,
    output logic      mask_q,
    output logic      irq_out
);

    import lvd_pkg::*;

    logic source_d_reg;
    logic source_rise;

    // ****************************************
    // Request flag
    // ****************************************
    // Edge detect so a held low supply raises one request
    assign source_rise = irq_source & ~source_d_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            source_d_reg <= 1'b0;
        end else begin
            source_d_reg <= irq_source;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_q <= 1'b0;
        end else if (source_rise) begin
            req_q <= 1'b1;
        end else if (req_wr) begin
            req_q <= req_wdata;
        end
    end

    // ****************************************
    // Mask flag
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_q <= MASK_RESET;
        end else if (mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    assign irq_out = req_q & ~mask_q;

endmodule

`default_nettype wire

// [src/lvd_pkg.sv]
// Constants shared by the low-voltage detect control block.
// Assumes an 8-bit register port with 16-bit byte addresses.
`default_nettype none

package lvd_pkg;

    // ****************************************
    // Register port widths
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CODE_W = 4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] DETECT_CONTROL_OFFS   = 16'hffbe;
    localparam logic [15:0] THRESHOLD_SELECT_OFFS = 16'hffbf;
    localparam logic [15:0] IRQ_REQUEST_0L_OFFS   = 16'hffe0;
    localparam logic [15:0] IRQ_MASK_0L_OFFS      = 16'hffe4;
    localparam logic [15:0] RESET_CAUSE_OFFS      = 16'hffa8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_ENABLE_POS = 7;
    localparam int CTRL_MODE_POS   = 1;
    localparam int CTRL_FLAG_POS   = 0;
    localparam int REQ_POS         = 0;
    localparam int MASK_POS        = 0;
    localparam int CAUSE_POS       = 0;

    // ****************************************
    // Reset values and code limits
    // ****************************************
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic       MASK_RESET   = 1'b1;
    localparam logic [3:0] CODE_MAX     = 4'h9;

endpackage

`default_nettype wire

// [src/lvd_sync2.sv]
// Two-flop synchroniser for the comparator level.
// Assumes the input is asynchronous to core_clk.
`default_nettype none

module lvd_sync2 (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_reg;

    // ****************************************
    // Capture chain
    // ****************************************
    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire
